// [inc/aux_pll_cfg.svh]
/*
 Constants for the auxiliary synthesizer configuration block: word select
 codes, field positions, reset values and divider constants.
 Assumes inclusion by bare name from the package and the core.
*/
`ifndef AUX_PLL_CFG_SVH
`define AUX_PLL_CFG_SVH

// ----------------------------------------------------------------------
// Word select codes
// ----------------------------------------------------------------------
`define CODE_AUX_DIV    4'h3
`define CODE_REF_PUMP   4'h5
`define CODE_FASTLOCK   4'h7

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define SEL_HI          3
`define SEL_LO          0
`define AUX_PD_BIT      23
`define AUX_P_BIT       22
`define AUX_CPG_BIT     21
`define AUX_N_HI        20
`define AUX_N_LO        4
`define REF_ZERO_HI     23
`define REF_ZERO_LO     22
`define MAIN_CPG_HI     21
`define MAIN_CPG_LO     18
`define REF_DIV_HI      17
`define REF_DIV_LO      3
`define FL_SLIP_HI      23
`define FL_SLIP_LO      22
`define FL_CPF_HI       21
`define FL_CPF_LO       18
`define FL_TOC_HI       17
`define FL_TOC_LO       4

// ----------------------------------------------------------------------
// Divider and pump constants
// ----------------------------------------------------------------------
`define PRESC_LO_MOD    5'h08
`define PRESC_HI_MOD    5'h10
`define PUMP_LOW_MA     3'h1
`define PUMP_HIGH_MA    3'h4
`define PUMP_STEP_UA    11'h064

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define RST_AUX_N       17'h00070
`define RST_REF_DIV     15'h0003
`define RST_GAIN        4'h0
`define RST_TOC         14'h0000
`define RST_SLIP        2'h0

`endif

// [inc/aux_pll_pkg.sv]
/*
 Types shared by the auxiliary synthesizer configuration block.
 Assumes aux_pll_cfg.svh is on the include path.
*/
`include "aux_pll_cfg.svh"

package aux_pll_pkg;
   typedef logic [23:0] word_t;
   typedef logic [16:0] aux_n_t;
   typedef logic [14:0] ref_div_t;
   typedef logic [3:0]  gain_t;
   typedef logic [13:0] toc_t;
   typedef logic [10:0] ua_t;
endpackage : aux_pll_pkg

// [core/aux_pll_divider_config.sv]
/*
 Serial configuration receiver and auxiliary synthesizer divider logic.
 A host shifts 24-bit words on link_clk; a rising load enable applies the
 word. Holds the aux feedback divider, aux reference divider, pump gains
 and power-down control, and the main fastlock settings.
 Assumes the host stops link_clk while load_en is high, so the shifted
 word is stable while the load edge crosses into the clk domain.
*/
// Overview of operation
// (RQ1) Prescaler bit picks modulus 8 or 16
// (RQ2) Main count N div P, swallow N mod P
// (RQ3) Host keeps main count at least swallow count
// (RQ4) N field is binary; bit 3 unused at 8/9
// (RQ5) Host keeps legal N values with 8/9
// (RQ6) Host keeps legal N values with 16/17
// (RQ7) Aux gain bit picks 1 mA or 4 mA
// (RQ8) Power-down stops synthesizer, pump goes high impedance
// (RQ9) Tristate bit: defer or immediate power-down
// (RQ10) Reference divides by 15-bit field, 3 upward
// (RQ11) Main pump current is 100 uA times code+1
// (RQ12) Reference word layout with code 0101
// (RQ13) Fastlock word layout with code 0111
// (RQ14) MSB first, low nibble selects, applied at load
// (RQ15) Swallow cycles by P+1, rest by P
`timescale 1ns/1ps
`include "aux_pll_cfg.svh"

module aux_pll_divider_config (
   input  wire logic              clk,
   input  wire logic              sys_rst,
   input  wire logic              link_clk,
   input  wire logic              link_data,
   input  wire logic              load_en,
   input  wire logic              aux_pump_tristate_ctrl,
   output logic                   aux_div_pulse,
   output logic                   aux_ref_pulse,
   output logic                   aux_pump_up,
   output logic                   aux_pump_dn,
   output logic                   aux_pump_hiz,
   output logic [2:0]             aux_pump_ma,
   output logic [4:0]             aux_presc_mod,
   output aux_pll_pkg::ua_t       main_pump_ua,
   output aux_pll_pkg::ua_t       main_fastlock_pump_ua,
   output aux_pll_pkg::toc_t      main_fastlock_timeout,
   output logic [1:0]             slip_reduction_select
);
   import aux_pll_pkg::*;

   // -------------------------------------------------------------------
   // Link domain shift register
   // -------------------------------------------------------------------
   word_t shift_q;

   always_ff @(posedge link_clk) begin
      shift_q <= {shift_q[22:0], link_data}; // [RQ14]
   end

   // -------------------------------------------------------------------
   // Load enable crossing and word capture
   // -------------------------------------------------------------------
   logic  le_s1_q;
   logic  le_s2_q;
   logic  le_s3_q;
   logic  apply_q;
   word_t word_q;
   wire   le_rise = le_s2_q & ~le_s3_q;

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         le_s1_q <= 1'b0;
         le_s2_q <= 1'b0;
         le_s3_q <= 1'b0;
         apply_q <= 1'b0;
         word_q  <= '0;
      end else begin
         le_s1_q <= load_en;
         le_s2_q <= le_s1_q;
         le_s3_q <= le_s2_q;
         apply_q <= le_rise; // [RQ14]
         if (le_rise) begin
            word_q <= shift_q;
         end
      end
   end

   // -------------------------------------------------------------------
   // Word decode
   // -------------------------------------------------------------------
   wire [3:0] sel_code = word_q[`SEL_HI:`SEL_LO];
   wire       ld_aux   = apply_q && (sel_code == `CODE_AUX_DIV);  // [RQ14]
   wire       ld_ref   = apply_q && (sel_code == `CODE_REF_PUMP); // [RQ12]
   wire       ld_fl    = apply_q && (sel_code == `CODE_FASTLOCK); // [RQ13]

   logic      aux_pd_q;
   logic      aux_p_q;
   logic      aux_cpg_q;
   aux_n_t    aux_n_q;
   ref_div_t  ref_div_q;
   gain_t     main_gain_q;
   gain_t     fl_gain_q;
   toc_t      fl_toc_q;
   logic [1:0] slip_q;

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         aux_pd_q  <= 1'b0;
         aux_p_q   <= 1'b0;
         aux_cpg_q <= 1'b0;
         aux_n_q   <= `RST_AUX_N;
      end else if (ld_aux) begin
         aux_pd_q  <= word_q[`AUX_PD_BIT];
         aux_p_q   <= word_q[`AUX_P_BIT];
         aux_cpg_q <= word_q[`AUX_CPG_BIT];
         aux_n_q   <= word_q[`AUX_N_HI:`AUX_N_LO]; // [RQ4]
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         ref_div_q   <= `RST_REF_DIV;
         main_gain_q <= `RST_GAIN;
      end else if (ld_ref) begin
         ref_div_q   <= word_q[`REF_DIV_HI:`REF_DIV_LO]; // [RQ10]
         main_gain_q <= word_q[`MAIN_CPG_HI:`MAIN_CPG_LO]; // [RQ12]
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         slip_q    <= `RST_SLIP;
         fl_gain_q <= `RST_GAIN;
         fl_toc_q  <= `RST_TOC;
      end else if (ld_fl) begin
         slip_q    <= word_q[`FL_SLIP_HI:`FL_SLIP_LO]; // [RQ13]
         fl_gain_q <= word_q[`FL_CPF_HI:`FL_CPF_LO];
         fl_toc_q  <= word_q[`FL_TOC_HI:`FL_TOC_LO];
      end
   end

   // -------------------------------------------------------------------
   // Power-down control
   // -------------------------------------------------------------------
   logic aux_off_q;
   logic pump_up_q;
   logic pump_dn_q;
   wire  pump_active = pump_up_q | pump_dn_q;
   // Without the tristate bit, wait for the pump to go idle first
   wire  aux_off_d = aux_pd_q &&
                     (aux_off_q || aux_pump_tristate_ctrl || !pump_active); // [RQ9]

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         aux_off_q <= 1'b0;
      end else begin
         aux_off_q <= aux_off_d; // [RQ8]
      end
   end

   // -------------------------------------------------------------------
   // Dual-modulus feedback divider
   // -------------------------------------------------------------------
   logic [4:0]  presc_q;
   logic [12:0] main_q;
   logic [3:0]  swal_q;
   logic        div_pulse_q;

   wire [4:0]  pmod      = aux_p_q ? `PRESC_HI_MOD : `PRESC_LO_MOD; // [RQ1]
   // Main count sits above bit 3 for both moduli, so bit 3 is a gap at 8/9
   wire [12:0] main_ld   = aux_n_q[16:4]; // [RQ2]
   wire [3:0]  swal_ld   = aux_p_q ? aux_n_q[3:0] : {1'b0, aux_n_q[2:0]}; // [RQ2] [RQ4]
   wire        presc_end = (presc_q == 5'h00);
   wire        main_last = (main_q <= 13'h0001);
   wire [3:0]  swal_dec  = (swal_q != 4'h0) ? swal_q - 4'h1 : 4'h0;
   wire [3:0]  swal_nx   = main_last ? swal_ld : swal_dec;
   wire [12:0] main_nx   = main_last ? main_ld : main_q - 13'h0001;
   // Count P+1 cycles while swallowing, P otherwise
   wire [4:0]  presc_nx  = (swal_nx != 4'h0) ? pmod : pmod - 5'h01; // [RQ15]
   wire [4:0]  presc_rs  = (swal_ld != 4'h0) ? pmod : pmod - 5'h01;
   wire        restart   = ld_aux || aux_off_q;

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         presc_q     <= 5'h00;
         main_q      <= 13'h0000;
         swal_q      <= 4'h0;
         div_pulse_q <= 1'b0;
      end else if (restart) begin
         presc_q     <= presc_rs;
         main_q      <= main_ld;
         swal_q      <= swal_ld;
         div_pulse_q <= 1'b0;
      end else if (presc_end) begin
         presc_q     <= presc_nx; // [RQ15]
         main_q      <= main_nx;
         swal_q      <= swal_nx;
         div_pulse_q <= main_last;
      end else begin
         presc_q     <= presc_q - 5'h01;
         div_pulse_q <= 1'b0;
      end
   end

   // -------------------------------------------------------------------
   // Reference divider
   // -------------------------------------------------------------------
   ref_div_t ref_cnt_q;
   logic     ref_pulse_q;
   wire      ref_end = (ref_cnt_q == 15'h0000);

   always_ff @(posedge clk) begin
      if (sys_rst || ld_ref || aux_off_q) begin
         ref_cnt_q   <= ref_div_q - 15'h0001;
         ref_pulse_q <= 1'b0;
      end else begin
         ref_cnt_q   <= ref_end ? ref_div_q - 15'h0001 : ref_cnt_q - 15'h0001; // [RQ10]
         ref_pulse_q <= ref_end;
      end
   end

   // -------------------------------------------------------------------
   // Phase detector and pump drive
   // -------------------------------------------------------------------
   wire up_d = !aux_off_q && !(pump_up_q && pump_dn_q) && (pump_up_q || ref_pulse_q);
   wire dn_d = !aux_off_q && !(pump_up_q && pump_dn_q) && (pump_dn_q || div_pulse_q);

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         pump_up_q <= 1'b0;
         pump_dn_q <= 1'b0;
      end else begin
         pump_up_q <= up_d; // [RQ8]
         pump_dn_q <= dn_d;
      end
   end

   // -------------------------------------------------------------------
   // Output settings
   // -------------------------------------------------------------------
   logic [2:0] pump_ma_q;
   logic [4:0] presc_mod_q;
   ua_t        main_ua_q;
   ua_t        fl_ua_q;
   toc_t       fl_toc_out_q;
   logic [1:0] slip_out_q;
   wire ua_t   main_ua_d = ({7'h00, main_gain_q} + 11'h001) * `PUMP_STEP_UA; // [RQ11]
   wire ua_t   fl_ua_d   = ({7'h00, fl_gain_q} + 11'h001) * `PUMP_STEP_UA;

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         pump_ma_q    <= `PUMP_LOW_MA;
         presc_mod_q  <= `PRESC_LO_MOD;
         main_ua_q    <= `PUMP_STEP_UA;
         fl_ua_q      <= `PUMP_STEP_UA;
         fl_toc_out_q <= `RST_TOC;
         slip_out_q   <= `RST_SLIP;
      end else begin
         pump_ma_q    <= aux_cpg_q ? `PUMP_HIGH_MA : `PUMP_LOW_MA; // [RQ7]
         presc_mod_q  <= pmod; // [RQ1]
         main_ua_q    <= main_ua_d;
         fl_ua_q      <= fl_ua_d;
         fl_toc_out_q <= fl_toc_q;
         slip_out_q   <= slip_q;
      end
   end

   assign aux_div_pulse         = div_pulse_q;
   assign aux_ref_pulse         = ref_pulse_q;
   assign aux_pump_up           = pump_up_q;
   assign aux_pump_dn           = pump_dn_q;
   assign aux_pump_hiz          = aux_off_q;
   assign aux_pump_ma           = pump_ma_q;
   assign aux_presc_mod         = presc_mod_q;
   assign main_pump_ua          = main_ua_q;
   assign main_fastlock_pump_ua = fl_ua_q;
   assign main_fastlock_timeout = fl_toc_out_q;
   assign slip_reduction_select = slip_out_q;

   // -------------------------------------------------------------------
   // Assertions
   // -------------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);

   a_aux_decode: assert property (ld_aux |=> aux_n_q == $past(word_q[`AUX_N_HI:`AUX_N_LO])) // [RQ14]
      else $error("aux word not applied");
   a_hold_no_load: assert property (!ld_aux |=> $stable(aux_n_q)) // [RQ14]
      else $error("aux divide changed without load");
   a_ref_decode: assert property (ld_ref |=> ref_div_q == $past(word_q[`REF_DIV_HI:`REF_DIV_LO]) // [RQ12]
                                  && main_gain_q == $past(word_q[`MAIN_CPG_HI:`MAIN_CPG_LO]))
      else $error("reference word fields wrong");
   a_fl_decode: assert property (ld_fl |=> slip_q == $past(word_q[`FL_SLIP_HI:`FL_SLIP_LO]) // [RQ13]
                                 && fl_gain_q == $past(word_q[`FL_CPF_HI:`FL_CPF_LO])
                                 && fl_toc_q == $past(word_q[`FL_TOC_HI:`FL_TOC_LO]))
      else $error("fastlock word fields wrong");
   a_presc_select: assert property (##1 aux_presc_mod == ($past(aux_p_q) ? 5'h10 : 5'h08)) // [RQ1]
      else $error("prescaler modulus wrong");
   a_swallow_len: assert property (!restart && presc_end && main_last // [RQ15]
                                   |=> presc_q == ((swal_ld != 4'h0) ? pmod : pmod - 5'h01))
      else $error("prescaler reload wrong");
   a_pump_current: assert property (##1 aux_pump_ma == ($past(aux_cpg_q) ? 3'h4 : 3'h1)) // [RQ7]
      else $error("aux pump current wrong");
   a_main_gain: assert property (##1 main_pump_ua == 11'(($past(main_gain_q) + 1) * 100)) // [RQ11]
      else $error("main pump current wrong");
   a_pd_defer: assert property (aux_pd_q && !aux_off_q && !aux_pump_tristate_ctrl && pump_active // [RQ9]
                                |=> !aux_pump_hiz)
      else $error("power-down not deferred");
   a_pd_immed: assert property (aux_pd_q && aux_pump_tristate_ctrl |=> aux_pump_hiz) // [RQ9]
      else $error("power-down not immediate");
   a_off_quiet: assert property (aux_off_q |=> !aux_pump_up && !aux_pump_dn && !aux_div_pulse) // [RQ8]
      else $error("pump active while powered down");

   // -------------------------------------------------------------------
   // Divider chain, reference, decode and output checks
   // -------------------------------------------------------------------
   a_swallow_step: assert property (!restart && presc_end && !main_last // [RQ15]
                                    |=> presc_q == (($past(swal_q) > 4'h1) ? pmod : pmod - 5'h01))
      else $error("swallow cycle length wrong");
   a_div_single: assert property (aux_div_pulse |=> !aux_div_pulse) // [RQ15]
      else $error("divider pulse longer than one cycle");
   a_ref_reload: assert property (ref_end && !ld_ref && !aux_off_q |=> ref_cnt_q == ref_div_q - 15'h0001) // [RQ10]
      else $error("reference divider reload wrong");
   a_ref_single: assert property (aux_ref_pulse |=> !aux_ref_pulse) // [RQ10]
      else $error("reference pulse longer than one cycle");
   a_aux_fields: assert property (ld_aux |=> aux_cpg_q == $past(word_q[`AUX_CPG_BIT]) // [RQ7]
                                  && aux_p_q == $past(word_q[`AUX_P_BIT]) && aux_pd_q == $past(word_q[`AUX_PD_BIT]))
      else $error("aux control bits not applied");
   a_ignored_code: assert property (apply_q && !ld_aux && !ld_ref && !ld_fl // [RQ14]
                                    |=> $stable(aux_n_q) && $stable(ref_div_q) && $stable(slip_q))
      else $error("word with unknown select code applied");
   a_hiz_release: assert property (!aux_pd_q |=> !aux_pump_hiz) // [RQ8]
      else $error("pump stays high impedance while running");
   a_fl_current: assert property (##1 main_fastlock_pump_ua == 11'(($past(fl_gain_q) + 1) * 100)) // [RQ13]
      else $error("fastlock pump current wrong");
   a_fl_timeout: assert property (##1 main_fastlock_timeout == $past(fl_toc_q)) // [RQ13]
      else $error("fastlock timeout output wrong");

   c_aux_load: cover property (ld_aux ##1 !aux_off_q);
   c_ref_load: cover property (ld_ref);
   c_fl_load: cover property (ld_fl);
   c_div_pulse: cover property (aux_div_pulse ##[1:300] aux_div_pulse);
   c_pd_defer: cover property (aux_pd_q && !aux_pump_tristate_ctrl && pump_active ##[1:300] aux_pump_hiz);

endmodule : aux_pll_divider_config

// [verification/host_link_model.sv]
/*
 Behavioural host that shifts 24-bit configuration words into the block.
 Assumes the bench calls send_word on a clk falling edge, with clk at 8 ns.
*/
`timescale 1ns/1ps

module host_link_model (
   output logic link_clk,
   output logic link_data,
   output logic load_en
);
   initial begin
      link_clk  = 1'b0;
      link_data = 1'b0;
      load_en   = 1'b0;
   end

   // ----------------------------------------------------------------------
   // Word transfer
   // ----------------------------------------------------------------------
   // The link clock runs only inside a frame; the load pulse lands between clk edges
   task automatic send_word(input logic [23:0] w);
      for (int i = 23; i >= 0; i--) begin
         link_data = w[i];
         #62.5 link_clk = 1'b1;
         #62.5 link_clk = 1'b0;
      end
      #102 load_en = 1'b1;
      #80 load_en = 1'b0;
      // Released line does not keep the last bit
      link_data = ~link_data;
      #80;
   endtask : send_word
endmodule : host_link_model

// [verification/tb.sv]
/*
 Self-checking bench for aux_pll_divider_config.
 Assumes the package and host_link_model are compiled first.
*/
`timescale 1ns/1ps

module tb;
   import aux_pll_pkg::*;
   typedef struct {logic [3:0] kind; logic [31:0] val;} note_s;
   logic        clk, sys_rst, aux_pump_tristate_ctrl, link_clk, link_data, load_en;
   logic        aux_div_pulse, aux_ref_pulse, aux_pump_up, aux_pump_dn, aux_pump_hiz;
   logic [2:0]  aux_pump_ma;
   logic [4:0]  aux_presc_mod;
   ua_t         main_pump_ua, main_fastlock_pump_ua;
   toc_t        main_fastlock_timeout;
   logic [1:0]  slip_reduction_select;
   logic        hiz_prev, pump_prev;
   note_s       notes[$];
   int          n_fail = 0;
   int          tests_run = 0;
   integer      seed;
   string       names[10] = '{"div_period", "ref_period", "aux_pump_ma", "presc_mod", "main_pump_ua",
                              "fastlock_ua", "timeout", "slip_select", "pump_hiz", "pump_busy_at_off"};

   host_link_model host (.link_clk(link_clk), .link_data(link_data), .load_en(load_en));

   aux_pll_divider_config uut (.clk(clk), .sys_rst(sys_rst), .link_clk(link_clk), .link_data(link_data),
      .load_en(load_en), .aux_pump_tristate_ctrl(aux_pump_tristate_ctrl), .aux_div_pulse(aux_div_pulse),
      .aux_ref_pulse(aux_ref_pulse), .aux_pump_up(aux_pump_up), .aux_pump_dn(aux_pump_dn),
      .aux_pump_hiz(aux_pump_hiz), .aux_pump_ma(aux_pump_ma), .aux_presc_mod(aux_presc_mod),
      .main_pump_ua(main_pump_ua), .main_fastlock_pump_ua(main_fastlock_pump_ua),
      .main_fastlock_timeout(main_fastlock_timeout), .slip_reduction_select(slip_reduction_select));

   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   // ----------------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------------
   function automatic logic [31:0] outv(input logic [3:0] k);
      case (k)
         4'h0:    outv = 32'(aux_div_pulse);
         4'h1:    outv = 32'(aux_ref_pulse);
         4'h2:    outv = 32'(aux_pump_ma);
         4'h3:    outv = 32'(aux_presc_mod);
         4'h4:    outv = 32'(main_pump_ua);
         4'h5:    outv = 32'(main_fastlock_pump_ua);
         4'h6:    outv = 32'(main_fastlock_timeout);
         4'h7:    outv = 32'(slip_reduction_select);
         default: outv = 32'(aux_pump_hiz);
      endcase
   endfunction : outv

   task automatic check(input logic [3:0] k, input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         n_fail++;
         $display("Error: %s expected %0d seen %0d", names[k], exp, seen);
      end
   endtask : check

   task automatic expect_val(input logic [3:0] k, input logic [31:0] v);
      notes.push_back('{k, v});
   endtask : expect_val

   task automatic drain();
      int k;
      k = 0;
      while (notes.size() != 0 && k < 100000) begin
         @(posedge clk);
         k++;
      end
   endtask : drain

   task automatic send(input logic [23:0] w);
      @(negedge clk);
      host.send_word(w);
   endtask : send

   task automatic wait_pulse(input logic [3:0] k, output logic [31:0] cnt);
      cnt = 0;
      do begin
         @(posedge clk);
         #1;
         cnt++;
      end while (outv(k) !== 32'h1 && cnt < 40000);
   endtask : wait_pulse

   task automatic stop_test();
      $display("Checks run %0d, mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : stop_test

   // ----------------------------------------------------------------------
   // Result watchers
   // ----------------------------------------------------------------------
   initial begin : watcher
      note_s       n;
      logic [31:0] seen;
      forever begin
         wait (notes.size() != 0);
         n = notes[0];
         if (n.kind < 4'h2) begin
            wait_pulse(n.kind, seen);
            wait_pulse(n.kind, seen);
            wait_pulse(n.kind, seen);
         end else begin
            seen = outv(n.kind);
         end
         check(n.kind, seen, n.val);
         void'(notes.pop_front());
      end
   end

   // Deferred power-down must land only on an idle pump
   always @(negedge clk) begin
      if (aux_pump_hiz === 1'b1 && hiz_prev === 1'b0 && aux_pump_tristate_ctrl === 1'b0)
         check(4'h9, 32'(pump_prev), 32'h0);
      hiz_prev  <= aux_pump_hiz;
      pump_prev <= aux_pump_up | aux_pump_dn;
   end

   initial begin : watchdog
      #700000;
      n_fail++;
      stop_test();
   end

   // ----------------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------------
   initial begin : main
      logic [31:0] r, nexp;
      logic [12:0] b;
      logic [3:0]  a;
      logic [4:0]  md;
      logic [14:0] rdiv;
      logic [13:0] tsave;
      int          k;
      sys_rst = 1'b1;
      aux_pump_tristate_ctrl = 1'b1;
      seed = 32'hA936FB07;
      repeat (2) @(posedge clk);
      sys_rst <= 1'b0;
      // Both prescalers and pump gains; first two at the smallest legal main count
      for (int i = 0; i < 4; i++) begin
         r = $random(seed);
         md = i[0] ? 5'h10 : 5'h08;
         b = (i < 2) ? 13'h3 : 13'(16 + r[3:0]);
         a = (i < 2) ? 4'h3 : (r[7:4] & 4'(md - 5'h01));
         nexp = md * b + a;
         send({1'b0, i[0], i[1], b, i[0] & a[3], a[2:0], 4'h3});
         expect_val(4'h3, 32'(md));
         expect_val(4'h2, i[1] ? 32'h4 : 32'h1);
         expect_val(4'h0, nexp);
         drain();
      end
      // Every gain code, with reference and fastlock words
      for (int c = 0; c < 16; c++) begin
         r = $random(seed);
         rdiv = (c == 0) ? 15'h4 : {6'h0, r[7:0], 1'b0} + 15'h4;
         tsave = r[31:18];
         send({2'b00, 4'(c), rdiv, 3'h5});
         send({2'(c), 4'(15 - c), tsave, 4'h7});
         expect_val(4'h4, 32'(100 * (c + 1)));
         expect_val(4'h5, 32'(100 * (16 - c)));
         expect_val(4'h6, 32'(tsave));
         expect_val(4'h7, 32'(c % 4));
         if (c < 3) expect_val(4'h1, 32'(rdiv));
         drain();
      end
      // Words with any other select code change nothing
      for (int s = 0; s < 16; s++) begin
         r = $random(seed);
         if (s != 3 && s != 5 && s != 7) send({r[19:0], 4'(s)});
      end
      expect_val(4'h4, 32'h640);
      expect_val(4'h7, 32'h3);
      expect_val(4'h6, 32'(tsave));
      expect_val(4'h3, 32'h10);
      expect_val(4'h2, 32'h4);
      drain();
      // Power-down immediate, release, then deferred
      send({3'b100, 13'h7, 4'h0, 4'h3});
      expect_val(4'h8, 32'h1);
      drain();
      send({3'b000, 13'h7, 4'h0, 4'h3});
      expect_val(4'h8, 32'h0);
      expect_val(4'h0, 32'h38);
      drain();
      @(posedge clk);
      aux_pump_tristate_ctrl <= 1'b0;
      send({3'b100, 13'h7, 4'h0, 4'h3});
      for (k = 0; k < 2000 && aux_pump_hiz !== 1'b1; k++) @(negedge clk);
      expect_val(4'h8, 32'h1);
      drain();
      stop_test();
   end
endmodule : tb
